// file: include/pcc_consts.vh
// register offsets, field positions, reset values and line and word counts for the program cache control block
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
`define PCC_ADDR_SIZE_CONFIG    32'h01840020
`define PCC_ADDR_FREEZE_CTRL    32'h01840024
`define PCC_ADDR_BLK_BASE       32'h01844020
`define PCC_ADDR_BLK_COUNT      32'h01844024
`define PCC_ADDR_GLOBAL_INVAL   32'h01845028
`define PCC_SIZE_MSB            2
`define PCC_SIZE_W              3
`define PCC_SIZE_RESET_OFF      3'h0
`define PCC_SIZE_RESET_MAX      3'h7
`define PCC_SIZE_OFF            3'h0
`define PCC_SIZE_4K             3'h1
`define PCC_SIZE_8K             3'h2
`define PCC_SIZE_16K            3'h3
`define PCC_SIZE_32K            3'h4
`define PCC_SIZE_MAX            3'h5
`define PCC_FREEZE_BIT          0
`define PCC_PREV_FREEZE_BIT     16
`define PCC_FREEZE_RESET        1'b0
`define PCC_COUNT_W             16
`define PCC_GINV_BIT            0
`define PCC_GINV_LINES          16'h0040
`define PCC_WORDS_PER_LINE      16'h0008
`endif

// file: rtl/pcc_size_decode.v
// decode of the cache size select field into an enable and a one-hot capacity
`include "pcc_consts.vh"
`default_nettype none
module pcc_size_decode (
    input  wire [2:0] size_sel_i,
    output reg        cache_enable_o,
    output reg  [4:0] capacity_onehot_o
);
    // one-hot: bit0 4K, bit1 8K, bit2 16K, bit3 32K, bit4 maximal
    always @* begin
        cache_enable_o    = 1'b1;
        capacity_onehot_o = 5'h00;
        case (size_sel_i)
            `PCC_SIZE_OFF: begin
                cache_enable_o = 1'b0;
            end
            `PCC_SIZE_4K:  capacity_onehot_o = 5'h01;
            `PCC_SIZE_8K:  capacity_onehot_o = 5'h02;
            `PCC_SIZE_16K: capacity_onehot_o = 5'h04;
            `PCC_SIZE_32K: capacity_onehot_o = 5'h08;
            default:       capacity_onehot_o = 5'h10;
        endcase
    end
endmodule
`default_nettype wire

// file: rtl/pcc_line_walker.v
// walks cache lines of an invalidation, one line index per cycle, for block and global requests
`default_nettype none
module pcc_line_walker #(
    parameter LINES = 64
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        start_i,
    input  wire [15:0] lines_i,
    output reg         busy_o,
    output reg  [15:0] line_idx_o,
    output reg         line_strobe_o,
    output wire        done_o
);
    reg [15:0] left_reg;
    // done pulses in the last busy cycle, one cycle before the last line strobe
    assign done_o = busy_o && (left_reg == 16'h0001);
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o        <= 1'b0;
            left_reg      <= 16'h0000;
            line_idx_o    <= 16'h0000;
            line_strobe_o <= 1'b0;
        end else begin
            line_strobe_o <= busy_o;
            if (busy_o) begin
                left_reg <= left_reg - 16'h0001;
                if (left_reg == 16'h0001) begin
                    busy_o <= 1'b0;
                end
            end else if (start_i && (lines_i != 16'h0000)) begin
                busy_o   <= 1'b1;
                left_reg <= lines_i;
            end
            // index steps after each strobe, so line 0 is the first one strobed
            if (!busy_o && start_i && (lines_i != 16'h0000)) begin
                line_idx_o <= 16'h0000;
            end else if (line_strobe_o) begin
                line_idx_o <= line_idx_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/pcc_top.v
// register file and invalidate sequencing for the program cache control block
`include "pcc_consts.vh"
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: size field bits 2-0 selects off, 4K, 8K, 16K, 32K or maximal capacity.
// R2: size field resets to 0h or 7h, chosen by a fixed device option; reset gives 0h here and 7h follows one edge after release.
// R3: freeze bit 0 enables freeze mode when 1; resets to 0.
// R4: bit 16 reads the freeze bit value held before the latest write.
// R5: block base is a 32-bit write-only start address of the invalidate range.
// R6: block count holds a 16-bit count of 32-bit words to invalidate.
// R7: block invalidation invalidates every line in range, never writing back.
// R8: writing 1 to global invalidate bit 0 invalidates every line, no writeback.
// R9: five registers decode at their fixed addresses.
// R10: only supervisor writes change the size; user reads it only.
// R11: both modes may start invalidations via base, count and global registers.
// R12: both modes may read and write the freeze register at any time.
// R13: second-level memory control writes may also act on the program cache.
// R14: software should avoid the legacy cache field of the processor status register.
// R15: freeze write copies old freeze bit to previous bit, then loads bit 0.
// R16: global invalidate bit clears itself once the whole invalidation finishes.
// R17: block word count becomes 0 once block invalidation finishes.
// R18: frozen cache serves hits, allocates nothing on misses, invalidates nothing; requested invalidations still run here while frozen.
// R19: user write to size register leaves register and size unchanged.
// R20: reserved bits read zero and ignore writes.
module pcc_top #(
    parameter SIZE_RESET_MAX = 0,
    parameter LINES          = 64,
    parameter WORDS_PER_LINE = 8
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [31:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire        supervisor_i,
    output reg  [31:0] rdata_o,
    input  wire        l2_global_inval_i,
    input  wire        l2_block_inval_i,
    input  wire [31:0] l2_block_base_i,
    input  wire [15:0] l2_block_count_i,
    output wire        cache_enable_o,
    output wire [4:0]  capacity_onehot_o,
    output wire [2:0]  cache_size_select_o,
    output wire        freeze_enable_o,
    output wire        allocate_enable_o,
    output wire        inval_busy_o,
    output wire        inval_line_strobe_o,
    output wire [15:0] inval_line_index_o,
    output wire        inval_all_o,
    output wire [31:0] inval_base_o,
    output wire        writeback_o
);
    localparam ST_IDLE   = 2'h0;
    localparam ST_GLOBAL = 2'h1;
    localparam ST_BLOCK  = 2'h2;

    reg  [2:0]  cache_size_select_reg;
    reg         freeze_enable_reg;
    reg         previous_freeze_enable_reg;
    reg  [31:0] block_base_reg;
    reg  [15:0] block_count_reg;
    reg         global_inval_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         strap_done_reg;
    reg  [31:0] rdata_next;
    reg         walk_start;
    reg  [15:0] walk_lines;
    wire        walk_busy;
    wire        walk_done;
    wire [15:0] walk_idx;
    wire        walk_strobe;
    wire        wr_size;
    wire        wr_freeze;
    wire        wr_base;
    wire        wr_count;
    wire        wr_ginv;
    wire [31:0] blk_words_rounded;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_size   = wr_i && (addr_i == `PCC_ADDR_SIZE_CONFIG); // R9
    assign wr_freeze = wr_i && (addr_i == `PCC_ADDR_FREEZE_CTRL); // R9
    assign wr_base   = wr_i && (addr_i == `PCC_ADDR_BLK_BASE); // R9
    assign wr_count  = wr_i && (addr_i == `PCC_ADDR_BLK_COUNT); // R9
    assign wr_ginv   = wr_i && (addr_i == `PCC_ADDR_GLOBAL_INVAL); // R9

    ////////////////////////////////////////////////////////////////////////////////////////////
    // size and freeze
    // the strap choice is loaded on the first edge after release, never inside the reset branch
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cache_size_select_reg <= `PCC_SIZE_RESET_OFF;
            strap_done_reg        <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
            if (!strap_done_reg) begin
                cache_size_select_reg <= (SIZE_RESET_MAX != 0) ? `PCC_SIZE_RESET_MAX : `PCC_SIZE_RESET_OFF; // R2
            end else if (wr_size && supervisor_i) begin // R10 R19
                cache_size_select_reg <= wdata_i[`PCC_SIZE_MSB:0]; // R1 R20
            end
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freeze_enable_reg          <= `PCC_FREEZE_RESET; // R3
            previous_freeze_enable_reg <= `PCC_FREEZE_RESET;
        end else if (wr_freeze) begin // R12
            previous_freeze_enable_reg <= freeze_enable_reg; // R4 R15
            freeze_enable_reg          <= wdata_i[`PCC_FREEZE_BIT]; // R3 R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // invalidate sequencing
    // a request of the other kind arriving during a walk stays pending in its register and starts afterwards;
    // one of the same kind is lost unless it arrives in the done cycle and is not an l2 block request
    assign blk_words_rounded = {16'h0000, block_count_reg} + WORDS_PER_LINE - 1;

    always @* begin
        state_next = state_reg;
        walk_start = 1'b0;
        walk_lines = 16'h0000;
        case (state_reg)
            ST_IDLE: begin
                if (global_inval_reg) begin // R8
                    state_next = ST_GLOBAL;
                    walk_start = 1'b1;
                    walk_lines = LINES[15:0];
                end else if (block_count_reg != 16'h0000) begin // R7
                    state_next = ST_BLOCK;
                    walk_start = 1'b1;
                    walk_lines = blk_words_rounded[18:3];
                end
            end
            ST_GLOBAL: begin
                if (walk_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_BLOCK: begin
                if (walk_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg        <= ST_IDLE;
            block_base_reg   <= 32'h00000000;
            block_count_reg  <= 16'h0000;
            global_inval_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // new set wins over completion clear in the same cycle, except an l2 block request during a block walk
            if (wr_ginv && wdata_i[`PCC_GINV_BIT]) begin // R11
                global_inval_reg <= 1'b1; // R8
            end else if (l2_global_inval_i) begin // R13
                global_inval_reg <= 1'b1;
            end else if (state_reg == ST_GLOBAL && walk_done) begin
                global_inval_reg <= 1'b0; // R16
            end
            if (wr_base) begin // R11
                block_base_reg <= wdata_i; // R5
            end else if (l2_block_inval_i && state_reg != ST_BLOCK) begin // R13
                block_base_reg <= l2_block_base_i;
            end
            if (wr_count) begin // R11
                block_count_reg <= wdata_i[`PCC_COUNT_W-1:0]; // R6 R20
            end else if (l2_block_inval_i && state_reg != ST_BLOCK) begin // R13
                block_count_reg <= l2_block_count_i;
            end else if (state_reg == ST_BLOCK && walk_done) begin
                block_count_reg <= 16'h0000; // R17
            end
        end
    end

    pcc_line_walker #(
        .LINES (LINES)
    ) u_walker (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .start_i       (walk_start),
        .lines_i       (walk_lines),
        .busy_o        (walk_busy),
        .line_idx_o    (walk_idx),
        .line_strobe_o (walk_strobe),
        .done_o        (walk_done)
    );

    pcc_size_decode u_size (
        .size_sel_i        (cache_size_select_reg),
        .cache_enable_o    (cache_enable_o),
        .capacity_onehot_o (capacity_onehot_o)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // read path; base register is write-only and reads zero
    always @* begin
        rdata_next = 32'h00000000; // R20
        if (addr_i == `PCC_ADDR_SIZE_CONFIG) begin
            rdata_next[`PCC_SIZE_MSB:0] = cache_size_select_reg;
        end else if (addr_i == `PCC_ADDR_FREEZE_CTRL) begin
            rdata_next[`PCC_FREEZE_BIT]      = freeze_enable_reg;
            rdata_next[`PCC_PREV_FREEZE_BIT] = previous_freeze_enable_reg; // R4
        end else if (addr_i == `PCC_ADDR_BLK_COUNT) begin
            rdata_next[`PCC_COUNT_W-1:0] = block_count_reg; // R17
        end else if (addr_i == `PCC_ADDR_GLOBAL_INVAL) begin
            rdata_next[`PCC_GINV_BIT] = global_inval_reg; // R16
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h00000000;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // cache tag outputs; invalidations run regardless of freeze, since software asked for them
    assign cache_size_select_o = cache_size_select_reg; // R1
    assign freeze_enable_o     = freeze_enable_reg; // R18
    assign allocate_enable_o   = cache_enable_o && !freeze_enable_reg; // R18
    assign inval_busy_o        = walk_busy;
    assign inval_line_strobe_o = walk_strobe; // R7 R8
    assign inval_line_index_o  = walk_idx;
    assign inval_all_o         = (state_reg == ST_GLOBAL);
    assign inval_base_o        = block_base_reg;
    assign writeback_o         = 1'b0; // R7 R8
endmodule
`default_nettype wire

// file: tb/pcc_top_chk.sv
// concurrent checks on the ports of the program cache control block
`include "pcc_consts.vh"
`default_nettype none
module pcc_top_chk (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        supervisor_i,
    input wire logic [31:0] rdata_o,
    input wire logic        cache_enable_o,
    input wire logic [4:0]  capacity_onehot_o,
    input wire logic [2:0]  cache_size_select_o,
    input wire logic        freeze_enable_o,
    input wire logic        allocate_enable_o,
    input wire logic        inval_busy_o,
    input wire logic        inval_line_strobe_o,
    input wire logic        inval_all_o,
    input wire logic        writeback_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_size;
    logic wr_frz;
    logic wr_ginv;
    assign wr_size = wr_i && (addr_i == `PCC_ADDR_SIZE_CONFIG);
    assign wr_frz  = wr_i && (addr_i == `PCC_ADDR_FREEZE_CTRL);
    assign wr_ginv = wr_i && (addr_i == `PCC_ADDR_GLOBAL_INVAL) && wdata_i[0];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
    property p_enable;
        cache_enable_o == (cache_size_select_o != 3'h0);
    endproperty
    a_enable: assert property (p_enable) else $error("cache enable wrong for size");
    property p_cap_max;
        cache_size_select_o >= 3'h5 |-> capacity_onehot_o == 5'h10;
    endproperty
    a_cap_max: assert property (p_cap_max) else $error("maximal capacity not selected");
    property p_cap_32k;
        cache_size_select_o == `PCC_SIZE_32K |-> capacity_onehot_o == 5'h08;
    endproperty
    a_cap_32k: assert property (p_cap_32k) else $error("32K capacity not selected");
    property p_alloc;
        allocate_enable_o == (cache_enable_o && !freeze_enable_o);
    endproperty
    a_alloc: assert property (p_alloc) else $error("allocation while frozen or disabled");
    property p_no_wb;
        writeback_o == 1'b0;
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("writeback requested");
    property p_sup_size;
        wr_size && supervisor_i |=> cache_size_select_o == $past(wdata_i[2:0]);
    endproperty
    a_sup_size: assert property (p_sup_size) else $error("supervisor size write not taken");
    property p_user_size;
        wr_size && !supervisor_i |=> $stable(cache_size_select_o);
    endproperty
    a_user_size: assert property (p_user_size) else $error("user size write changed size");
    property p_frz_load;
        wr_frz |=> freeze_enable_o == $past(wdata_i[0]);
    endproperty
    a_frz_load: assert property (p_frz_load) else $error("freeze bit not loaded");
    property p_frz_hold;
        !wr_frz |=> $stable(freeze_enable_o);
    endproperty
    a_frz_hold: assert property (p_frz_hold) else $error("freeze bit changed without write");
    property p_strobe;
        inval_line_strobe_o |-> $past(inval_busy_o);
    endproperty
    a_strobe: assert property (p_strobe) else $error("line strobe without busy walk");
    property p_ginv_start;
        wr_ginv && !inval_busy_o |-> ##[1:3] (inval_busy_o && inval_all_o);
    endproperty
    a_ginv_start: assert property (p_ginv_start) else $error("global walk did not start");
endmodule
bind pcc_top pcc_top_chk u_chk (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .supervisor_i, .rdata_o,
    .cache_enable_o, .capacity_onehot_o, .cache_size_select_o, .freeze_enable_o, .allocate_enable_o,
    .inval_busy_o, .inval_line_strobe_o, .inval_all_o, .writeback_o);
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the program cache control block
`include "pcc_consts.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LINES = 4;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [31:0] addr_i = 32'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        supervisor_i = 1'b0;
    logic        l2_global_inval_i = 1'b0;
    logic        l2_block_inval_i = 1'b0;
    logic [31:0] l2_block_base_i = 32'h0;
    logic [15:0] l2_block_count_i = 16'h0;
    logic [31:0] rdata_o;
    logic        cache_enable_o;
    logic [4:0]  capacity_onehot_o;
    logic [2:0]  cache_size_select_o;
    logic        freeze_enable_o;
    logic        allocate_enable_o;
    logic        inval_busy_o;
    logic        inval_line_strobe_o;
    logic [15:0] inval_line_index_o;
    logic        inval_all_o;
    logic [31:0] inval_base_o;
    logic        writeback_o;
    logic [2:0]  max_size_select;
    int          n_fail = 0;
    int          cmp_count = 0;
    // small line count keeps global walks short
    pcc_top #(.LINES(LINES)) dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .supervisor_i, .rdata_o,
        .l2_global_inval_i, .l2_block_inval_i, .l2_block_base_i, .l2_block_count_i, .cache_enable_o,
        .capacity_onehot_o, .cache_size_select_o, .freeze_enable_o, .allocate_enable_o, .inval_busy_o,
        .inval_line_strobe_o, .inval_line_index_o, .inval_all_o, .inval_base_o, .writeback_o);
    // second instance takes the maximal size strap
    pcc_top #(.LINES(LINES), .SIZE_RESET_MAX(1)) dut_max (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .supervisor_i, .rdata_o(), .l2_global_inval_i, .l2_block_inval_i, .l2_block_base_i, .l2_block_count_i,
        .cache_enable_o(), .capacity_onehot_o(), .cache_size_select_o(max_size_select), .freeze_enable_o(),
        .allocate_enable_o(), .inval_busy_o(), .inval_line_strobe_o(), .inval_line_index_o(), .inval_all_o(),
        .inval_base_o(), .writeback_o());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic sup);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        supervisor_i <= sup;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    // counts strobes of one walk and checks line index order
    task automatic walk(input int exp_lines, input logic exp_all);
        int n;
        bit seen;
        n = 0;
        seen = 1'b0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_i);
            #1;
            if (!seen && inval_busy_o === 1'b1) begin
                seen = 1'b1;
                chk(inval_all_o, exp_all);
            end
            if (inval_line_strobe_o === 1'b1) begin
                chk(inval_line_index_o, n);
                n++;
            end
            if (seen && inval_busy_o === 1'b0 && inval_line_strobe_o === 1'b0)
                break;
        end
        chk(n, exp_lines);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`PCC_ADDR_SIZE_CONFIG, 32'h0);
        chk(max_size_select, `PCC_SIZE_RESET_MAX);
        rd(`PCC_ADDR_FREEZE_CTRL, 32'h0);
        rd(`PCC_ADDR_BLK_COUNT, 32'h0);
        rd(`PCC_ADDR_GLOBAL_INVAL, 32'h0);
        rd(32'h01840028, 32'h0);
        chk(writeback_o, 32'h0);
    endtask
    task automatic t_size();
        for (int s = 0; s < 8; s++) begin
            wr(`PCC_ADDR_SIZE_CONFIG, 32'hffff_fff8 | s, 1'b1);
            rd(`PCC_ADDR_SIZE_CONFIG, s);
            chk(capacity_onehot_o, s == 0 ? 5'h00 : s >= 5 ? 5'h10 : 5'h01 << (s - 1));
            chk(cache_enable_o, s != 0);
        end
        wr(`PCC_ADDR_SIZE_CONFIG, 32'h2, 1'b0);
        rd(`PCC_ADDR_SIZE_CONFIG, 32'h7);
    endtask
    task automatic t_freeze();
        wr(`PCC_ADDR_FREEZE_CTRL, 32'h0001_0001, 1'b0);
        rd(`PCC_ADDR_FREEZE_CTRL, 32'h0000_0001);
        chk(allocate_enable_o, 32'h0);
        wr(`PCC_ADDR_FREEZE_CTRL, 32'h0, 1'b1);
        rd(`PCC_ADDR_FREEZE_CTRL, 32'h0001_0000);
        chk(allocate_enable_o, 32'h1);
        wr(`PCC_ADDR_FREEZE_CTRL, 32'hffff_fffe, 1'b0);
        rd(`PCC_ADDR_FREEZE_CTRL, 32'h0);
    endtask
    task automatic t_global();
        fork
            walk(LINES, 1'b1);
            begin
                wr(`PCC_ADDR_GLOBAL_INVAL, 32'h1, 1'b0);
                rd(`PCC_ADDR_GLOBAL_INVAL, 32'h1);
            end
        join
        rd(`PCC_ADDR_GLOBAL_INVAL, 32'h0);
    endtask
    task automatic t_block();
        wr(`PCC_ADDR_BLK_BASE, 32'h0000_1240, 1'b0);
        rd(`PCC_ADDR_BLK_BASE, 32'h0);
        chk(inval_base_o, 32'h0000_1240);
        fork
            walk(3, 1'b0);
            begin
                wr(`PCC_ADDR_BLK_COUNT, 32'hffff_0011, 1'b0);
                rd(`PCC_ADDR_BLK_COUNT, 32'h0000_0011);
            end
        join
        rd(`PCC_ADDR_BLK_COUNT, 32'h0);
    endtask
    task automatic t_l2();
        fork
            walk(LINES, 1'b1);
            begin
                @(posedge clk_i);
                l2_global_inval_i <= 1'b1;
                @(posedge clk_i);
                l2_global_inval_i <= 1'b0;
            end
        join
        fork
            walk(2, 1'b0);
            begin
                @(posedge clk_i);
                l2_block_base_i <= 32'h0000_8000;
                l2_block_count_i <= 16'h0009;
                l2_block_inval_i <= 1'b1;
                @(posedge clk_i);
                l2_block_inval_i <= 1'b0;
            end
        join
        chk(inval_base_o, 32'h0000_8000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #(40 * 20000);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_size();
        t_freeze();
        t_global();
        t_block();
        t_l2();
        tally_and_finish();
    end
endmodule
`default_nettype wire
